// [rtl/dft_pkg.sv]
// Package of the dynamic fan threshold block: register indices, field layouts and reset values.
// It assumes a single 50 MHz clock and register indices that are turned into byte addresses by x4.
`default_nettype none
package dft_pkg;
  localparam int NCH = 3;
  // Register indices; the byte address is four times the index.
  localparam logic [9:0] IDX_TARGET_R1 = 10'h033;
  localparam logic [9:0] IDX_TARGET_LOC = 10'h034;
  localparam logic [9:0] IDX_TARGET_R2 = 10'h035;
  localparam logic [9:0] IDX_LOW_R1 = 10'h04E;
  localparam logic [9:0] IDX_HIGH_R1 = 10'h04F;
  localparam logic [9:0] IDX_LOW_LOC = 10'h050;
  localparam logic [9:0] IDX_HIGH_LOC = 10'h051;
  localparam logic [9:0] IDX_LOW_R2 = 10'h052;
  localparam logic [9:0] IDX_HIGH_R2 = 10'h053;
  localparam logic [9:0] IDX_CRIT_R1 = 10'h06A;
  localparam logic [9:0] IDX_CRIT_LOC = 10'h06B;
  localparam logic [9:0] IDX_CRIT_R2 = 10'h06C;
  localparam logic [9:0] IDX_CTRL = 10'h070;
  localparam logic [9:0] IDX_CYCLE = 10'h071;
  localparam logic [9:0] IDX_RANGE = 10'h072;
  localparam logic [9:0] IDX_STATUS = 10'h073;
  localparam logic [9:0] IDX_START_R1 = 10'h074;
  localparam logic [9:0] IDX_TEMP_R1 = 10'h078;
  // Reset values.
  localparam logic [7:0] RST_TARGET = 8'hA4;
  localparam logic [7:0] RST_LOW = 8'h01;
  localparam logic [7:0] RST_HIGH = 8'h7F;
  localparam logic [7:0] RST_CRIT = 8'hA4;
  localparam logic [7:0] RST_START = 8'h5A;
  localparam logic [1:0] RST_CTRL = 2'h0;
  localparam logic [8:0] RST_CYCLE = 9'h000;
  localparam logic [8:0] RST_RANGE = 9'h000;
  localparam logic [8:0] RST_STATUS = 9'h000;
  // Field positions.
  localparam int CTRL_DYN_EN = 0;
  localparam int CTRL_ALERT_EN = 1;
  localparam int FLD_W = 3;
  localparam int ST_LOW = 0;
  localparam int ST_HIGH = 3;
  localparam int ST_CRIT = 6;
  // Counts of monitoring cycles and temperatures, full duty value and bus response codes.
  localparam logic [10:0] SHORT_BASE = 11'h008;
  localparam logic [7:0] CRIT_HYST = 8'h04;
  localparam logic [7:0] DUTY_FULL = 8'hFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// [rtl/dft_chan.sv]
// One temperature channel's fan start threshold and its adjustment loop.
// It assumes one monitor_tick pulse per finished monitoring cycle and a stable measured value.
`default_nettype none
module dft_chan
  import dft_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Loop inputs.
  input wire logic tick,
  input wire logic dyn_en,
  input wire logic [2:0] cycle_code,
  input wire logic [7:0] temp,
  input wire logic [7:0] target,
  input wire logic [7:0] low_lim,
  input wire logic [7:0] high_lim,
  // Software access to the start temperature.
  input wire logic sw_we,
  input wire logic [7:0] sw_data,
  // Threshold out.
  output logic [7:0] start_q
);
  logic [10:0] cnt_q;
  logic [10:0] cnt_d;
  logic [7:0] prev_q;
  logic [7:0] start_d;
  wire [10:0] short_len = SHORT_BASE << cycle_code;
  wire [10:0] long_len = short_len << 1;
  wire long_hit = tick && (cnt_q >= long_len - 11'h001);
  wire short_hit = tick && ((cnt_q == short_len - 11'h001) || long_hit);
  wire above_op = temp > target;
  wire rising = temp > prev_q;
  // The long cycle steps down one degree, the short cycle one more while still climbing.
  wire [7:0] dec = {7'h00, long_hit && above_op} + {7'h00, short_hit && above_op && rising};
  // Raising stops at the high limit and at the target, so the fan still starts before the target.
  wire inc = long_hit && (temp < low_lim) && (start_q < high_lim) && (start_q < target);

  assign cnt_d = long_hit ? 11'h000 : (tick ? cnt_q + 11'h001 : cnt_q);

  always_comb begin
    start_d = start_q;
    if (sw_we) begin
      start_d = sw_data;
    end else if (dyn_en && inc) begin
      start_d = start_q + 8'h01;
    end else if (dyn_en && (dec != 8'h00)) begin
      start_d = (start_q > dec) ? start_q - dec : 8'h00;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cnt_q <= 11'h000;
      prev_q <= 8'h00;
      start_q <= RST_START;
    end else begin
      cnt_q <= cnt_d;
      prev_q <= short_hit ? temp : prev_q;
      start_q <= start_d;
    end
  end
endmodule
`default_nettype wire

// [rtl/dft_top.sv]
// Dynamic fan threshold control: AXI4-Lite register file, limit flags, critical override
// and per-channel fan duty. It assumes temperatures arrive as 8-bit degree values, one
// update per monitor_tick, in the same encoding as every target and limit register.
//
// Function
// - Dynamic mode moves each fan start temperature on top of the fan loop.
// - Three 8-bit target temperature registers, one degree per step.
// - Targets sit at indices 0x33, 0x34, 0x35 and reset to 0xA4.
// - Temperature below low limit sets a status flag and may raise alert.
// - Temperature above high limit sets a status flag and may raise alert.
// - A fan switches on at its channel's start temperature.
// - Above the critical limit all fans run at full duty.
// - A per-channel range setting sets duty slope above start temperature.
// - Below the low limit the start temperature is raised.
// - Above the target the start temperature is lowered.
// - Each zone runs its own loop toward its own target.
// - Short cycle every n monitoring cycles, long cycle every 2n.
// - Start temperature is never raised past the high limit.
//
// Chosen here: the AXI4-Lite register port.
`default_nettype none
module dft_top
  import dft_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // AXI4-Lite write address.
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address.
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Measured temperatures.
  input wire logic monitor_tick,
  input wire logic [7:0] temp_remote1,
  input wire logic [7:0] temp_local,
  input wire logic [7:0] temp_remote2,
  // Fan drive and alert.
  output logic [7:0] fan_duty_remote1,
  output logic [7:0] fan_duty_local,
  output logic [7:0] fan_duty_remote2,
  output logic [2:0] fan_on,
  output logic smbalert_b
);
  // Register state.
  logic [7:0] target_q [NCH];
  logic [7:0] low_q [NCH];
  logic [7:0] high_q [NCH];
  logic [7:0] crit_lim_q [NCH];
  logic [1:0] ctrl_q;
  logic [8:0] cycle_q;
  logic [8:0] range_q;
  logic [8:0] status_q;
  logic [8:0] status_d;
  logic [NCH-1:0] crit_q;
  logic [NCH-1:0] crit_d;
  logic [7:0] start_w [NCH];
  logic [7:0] temp_w [NCH];
  logic [7:0] duty_q [NCH];
  logic [7:0] duty_d [NCH];
  logic [NCH-1:0] on_q;
  logic alert_b_q;
  // Bus state.
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_word;
  logic rd_hit;

  // Merges the enabled byte lanes of a write into a register's current value.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Duty from temperature: off below start, slope set by range, full when critical.
  function automatic logic [7:0] duty_of(input logic [7:0] t, input logic [7:0] st,
                                         input logic [2:0] rng, input logic full);
    logic [15:0] ramp;
    ramp = 16'h0000;
    if (t >= st) begin
      ramp = {8'h00, t - st} << rng;
    end
    if (full) begin
      return DUTY_FULL;
    end
    return (ramp > {8'h00, DUTY_FULL}) ? DUTY_FULL : ramp[7:0];
  endfunction

  assign temp_w[0] = temp_remote1;
  assign temp_w[1] = temp_local;
  assign temp_w[2] = temp_remote2;

  // Write channel: both address and data are taken together, one write at a time.
  wire wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  wire [9:0] wr_idx = s_axi_awaddr[11:2];
  wire [9:0] rd_idx = s_axi_araddr[11:2];
  wire rd_go = s_axi_arvalid && !rvalid_q;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // Write decode.
  wire we_ctrl = wr_go && (wr_idx == IDX_CTRL);
  wire we_cycle = wr_go && (wr_idx == IDX_CYCLE);
  wire we_range = wr_go && (wr_idx == IDX_RANGE);
  wire we_status = wr_go && (wr_idx == IDX_STATUS);
  wire [31:0] wr_tgt = merge({24'h0, target_q[wr_idx[1:0] - 2'h3]}, s_axi_wdata, s_axi_wstrb);
  wire [31:0] wr_ctrl = merge({30'h0, ctrl_q}, s_axi_wdata, s_axi_wstrb);
  wire [31:0] wr_cycle = merge({23'h0, cycle_q}, s_axi_wdata, s_axi_wstrb);
  wire [31:0] wr_range = merge({23'h0, range_q}, s_axi_wdata, s_axi_wstrb);
  wire [31:0] wr_clr = merge(32'h0, s_axi_wdata, s_axi_wstrb);
  logic [NCH-1:0] we_tgt;
  logic [NCH-1:0] we_low;
  logic [NCH-1:0] we_high;
  logic [NCH-1:0] we_crit;
  logic [NCH-1:0] we_start;
  logic [NCH-1:0] set_low;
  logic [NCH-1:0] set_high;
  logic [NCH-1:0] wr_known;

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    wire [9:0] cv = 10'(c);
    // Byte-lane merges of a write into this channel's registers.
    wire [31:0] wr_low = merge({24'h0, low_q[c]}, s_axi_wdata, s_axi_wstrb);
    wire [31:0] wr_high = merge({24'h0, high_q[c]}, s_axi_wdata, s_axi_wstrb);
    wire [31:0] wr_crit = merge({24'h0, crit_lim_q[c]}, s_axi_wdata, s_axi_wstrb);
    wire [31:0] wr_start = merge({24'h0, start_w[c]}, s_axi_wdata, s_axi_wstrb);
    assign we_tgt[c] = wr_go && (wr_idx == IDX_TARGET_R1 + cv);
    assign we_low[c] = wr_go && (wr_idx == IDX_LOW_R1 + (cv << 1));
    assign we_high[c] = wr_go && (wr_idx == IDX_HIGH_R1 + (cv << 1));
    assign we_crit[c] = wr_go && (wr_idx == IDX_CRIT_R1 + cv);
    assign we_start[c] = wr_go && (wr_idx == IDX_START_R1 + cv);
    assign wr_known[c] = we_tgt[c] | we_low[c] | we_high[c] | we_crit[c] | we_start[c];
    // Comparisons are direct because every value shares the measured encoding.
    assign set_low[c] = monitor_tick && (temp_w[c] < low_q[c]);
    assign set_high[c] = monitor_tick && (temp_w[c] > high_q[c]);
    // The critical state holds until the temperature falls more than a hysteresis below the limit.
    assign crit_d[c] = (temp_w[c] > crit_lim_q[c]) ||
                       (crit_q[c] && (temp_w[c] >= crit_lim_q[c] - CRIT_HYST));
    assign duty_d[c] = duty_of(temp_w[c], start_w[c], range_q[FLD_W*c +: FLD_W], |crit_q);

    // Each zone has its own loop, counter and target.
    dft_chan u_chan (
      .mclk(mclk),
      .rst_b(rst_b),
      .tick(monitor_tick),
      .dyn_en(ctrl_q[CTRL_DYN_EN]),
      .cycle_code(cycle_q[FLD_W*c +: FLD_W]),
      .temp(temp_w[c]),
      .target(target_q[c]),
      .low_lim(low_q[c]),
      .high_lim(high_q[c]),
      .sw_we(we_start[c]),
      .sw_data(wr_start[7:0]),
      .start_q(start_w[c])
    );

    always_ff @(posedge mclk) begin
      if (!rst_b) begin
        target_q[c] <= RST_TARGET;
        low_q[c] <= RST_LOW;
        high_q[c] <= RST_HIGH;
        crit_lim_q[c] <= RST_CRIT;
        crit_q[c] <= 1'b0;
        duty_q[c] <= 8'h00;
        on_q[c] <= 1'b0;
      end else begin
        target_q[c] <= we_tgt[c] ? wr_tgt[7:0] : target_q[c];
        low_q[c] <= we_low[c] ? wr_low[7:0] : low_q[c];
        high_q[c] <= we_high[c] ? wr_high[7:0] : high_q[c];
        crit_lim_q[c] <= we_crit[c] ? wr_crit[7:0] : crit_lim_q[c];
        crit_q[c] <= crit_d[c];
        duty_q[c] <= duty_d[c];
        on_q[c] <= (temp_w[c] >= start_w[c]) || (|crit_q);
      end
    end
  end

  wire wr_hit = (|wr_known) || we_ctrl || we_cycle || we_range || we_status;

  // A new event outweighs a clear arriving in the same cycle.
  assign status_d = (status_q & ~(we_status ? wr_clr[8:0] : 9'h000)) |
                    {crit_d & {NCH{monitor_tick}}, set_high, set_low};

  // Read decode.
  always_comb begin
    rd_word = 32'h0;
    rd_hit = 1'b1;
    unique case (rd_idx)
      IDX_TARGET_R1: rd_word = {24'h0, target_q[0]};
      IDX_TARGET_LOC: rd_word = {24'h0, target_q[1]};
      IDX_TARGET_R2: rd_word = {24'h0, target_q[2]};
      IDX_LOW_R1: rd_word = {24'h0, low_q[0]};
      IDX_HIGH_R1: rd_word = {24'h0, high_q[0]};
      IDX_LOW_LOC: rd_word = {24'h0, low_q[1]};
      IDX_HIGH_LOC: rd_word = {24'h0, high_q[1]};
      IDX_LOW_R2: rd_word = {24'h0, low_q[2]};
      IDX_HIGH_R2: rd_word = {24'h0, high_q[2]};
      IDX_CRIT_R1: rd_word = {24'h0, crit_lim_q[0]};
      IDX_CRIT_LOC: rd_word = {24'h0, crit_lim_q[1]};
      IDX_CRIT_R2: rd_word = {24'h0, crit_lim_q[2]};
      IDX_CTRL: rd_word = {30'h0, ctrl_q};
      IDX_CYCLE: rd_word = {23'h0, cycle_q};
      IDX_RANGE: rd_word = {23'h0, range_q};
      IDX_STATUS: rd_word = {23'h0, status_q};
      IDX_START_R1: rd_word = {24'h0, start_w[0]};
      IDX_START_R1 + 10'h001: rd_word = {24'h0, start_w[1]};
      IDX_START_R1 + 10'h002: rd_word = {24'h0, start_w[2]};
      IDX_TEMP_R1: rd_word = {24'h0, temp_w[0]};
      IDX_TEMP_R1 + 10'h001: rd_word = {24'h0, temp_w[1]};
      IDX_TEMP_R1 + 10'h002: rd_word = {24'h0, temp_w[2]};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ctrl_q <= RST_CTRL;
      cycle_q <= RST_CYCLE;
      range_q <= RST_RANGE;
      status_q <= RST_STATUS;
      alert_b_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0;
    end else begin
      ctrl_q <= we_ctrl ? wr_ctrl[1:0] : ctrl_q;
      cycle_q <= we_cycle ? wr_cycle[8:0] : cycle_q;
      range_q <= we_range ? wr_range[8:0] : range_q;
      status_q <= status_d;
      // Alert follows the sticky flags, so it stays low until software clears them.
      alert_b_q <= !(ctrl_q[CTRL_ALERT_EN] && (|status_q));
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (rd_go) begin
        rvalid_q <= 1'b1;
        rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        rdata_q <= rd_word;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign fan_duty_remote1 = duty_q[0];
  assign fan_duty_local = duty_q[1];
  assign fan_duty_remote2 = duty_q[2];
  assign fan_on = on_q;
  assign smbalert_b = alert_b_q;
endmodule
`default_nettype wire

// [test/dft_chk_checker.sv]
// Checker of the threshold block: bus handshakes, fan drive and critical override.
// Bound into dft_top; it sees only that module's ports.
`default_nettype none
module dft_chk
  import dft_pkg::*;
(
  // Clock and reset.
  input wire logic mclk, rst_b,
  // Register bus.
  input wire logic [11:0] s_axi_awaddr, s_axi_araddr,
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic s_axi_rvalid, s_axi_rready,
  input wire logic [1:0] s_axi_bresp, s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  // Fan drive.
  input wire logic [7:0] fan_duty_remote1, fan_duty_local, fan_duty_remote2,
  input wire logic [2:0] fan_on
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire logic wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire logic rd_take = s_axi_arvalid && s_axi_arready;
  wire logic all_full = (fan_duty_remote1 & fan_duty_local & fan_duty_remote2) == 8'hFF;
  wr_answer_a: assert property (wr_take |=> s_axi_bvalid)
    else $error("write not answered after one cycle");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  rd_answer_a: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered after one cycle");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  unmapped_err_a: assert property (wr_take && s_axi_awaddr == 12'hFFC |=> s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  target_width_a: assert property (rd_take && s_axi_araddr inside {12'h0CC, 12'h0D0, 12'h0D4}
    |=> s_axi_rresp == RESP_OKAY && s_axi_rdata[31:8] == 24'h0) else $error("target read too wide");
  fan_off_a: assert property (!fan_on[0] |-> fan_duty_remote1 == 8'h00)
    else $error("duty without fan on");
  crit_all_a: assert property (all_full |-> fan_on == 3'h7)
    else $error("full duty without all fans on");
endmodule
bind dft_top dft_chk dft_chk_inst (.mclk(mclk), .rst_b(rst_b),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_araddr(s_axi_araddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_bresp(s_axi_bresp), .s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata),
  .fan_duty_remote1(fan_duty_remote1), .fan_duty_local(fan_duty_local),
  .fan_duty_remote2(fan_duty_remote2), .fan_on(fan_on));
`default_nettype wire

// [test/dft_host.sv]
// Host model: an AXI4-Lite master that programs the threshold registers.
// It assumes one clock shared with the block; tasks are called from the bench.
`default_nettype none
module dft_host (
  // Clock.
  input wire logic mclk,
  // Requests.
  output logic [11:0] s_axi_awaddr, s_axi_araddr,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
  // Answers.
  input wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid,
  input wire logic [1:0] s_axi_bresp, s_axi_rresp,
  input wire logic [31:0] s_axi_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
  end
  // Ready is raised a cycle late on purpose, so the slave must hold its answer.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge mclk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    @(posedge mclk);
    s_axi_bready <= 1'b1;
    do @(posedge mclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge mclk);
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [test/tb.sv]
// Self-checking bench of the dynamic fan threshold block.
// Registers go through the host model; temperatures and ticks are driven here.
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
  import dft_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, rst_b = 1'b0, monitor_tick = 1'b0;
  logic [7:0] t1 = 8'h40, tl = 8'h40, t2 = 8'h40, d1, dl, d2;
  logic [11:0] awa, ara;
  logic [31:0] wdt, rdt, d;
  logic [3:0] wst;
  logic awv, awr, wvl, wrd, bvl, brd, arv, arr, rvl, rrd, alb;
  logic [1:0] brs, rrs, r;
  logic [2:0] fon;
  int err_total = 0, n_compared = 0;
  always #10 mclk = ~mclk;
  dft_top dft_top_inst (.mclk(mclk), .rst_b(rst_b), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdt), .s_axi_wstrb(wst), .s_axi_wvalid(wvl),
    .s_axi_wready(wrd), .s_axi_bresp(brs), .s_axi_bvalid(bvl), .s_axi_bready(brd),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
    .s_axi_rresp(rrs), .s_axi_rvalid(rvl), .s_axi_rready(rrd), .monitor_tick(monitor_tick),
    .temp_remote1(t1), .temp_local(tl), .temp_remote2(t2), .fan_duty_remote1(d1),
    .fan_duty_local(dl), .fan_duty_remote2(d2), .fan_on(fon), .smbalert_b(alb));
  dft_host dft_host_inst (.mclk(mclk), .s_axi_awaddr(awa), .s_axi_araddr(ara),
    .s_axi_wdata(wdt), .s_axi_wstrb(wst), .s_axi_awvalid(awv), .s_axi_wvalid(wvl),
    .s_axi_bready(brd), .s_axi_arvalid(arv), .s_axi_rready(rrd), .s_axi_awready(awr),
    .s_axi_wready(wrd), .s_axi_bvalid(bvl), .s_axi_arready(arr), .s_axi_rvalid(rvl),
    .s_axi_bresp(brs), .s_axi_rresp(rrs), .s_axi_rdata(rdt));
  task automatic wr(input logic [9:0] i, input logic [31:0] v);
    dft_host_inst.wr({i, 2'b00}, v, r);
    `CHK(r, RESP_OKAY)
  endtask
  task automatic rd(input logic [9:0] i, input logic [31:0] e);
    dft_host_inst.rd({i, 2'b00}, d, r);
    `CHK({r, d}, {RESP_OKAY, e})
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge mclk);
      monitor_tick <= 1'b1;
      @(posedge mclk);
      monitor_tick <= 1'b0;
    end
  endtask
  task automatic test_done();
    $display("Counts: %0d compared, %0d mismatched", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    for (int k = 0; k < 3; k++) rd(IDX_TARGET_R1 + 10'(k), {24'h0, RST_TARGET});
    wr(IDX_TARGET_R1, 32'hFFFF_FFC7);
    rd(IDX_TARGET_R1, 32'h0000_00C7);
    dft_host_inst.rd(12'hFFC, d, r);
    `CHK({r, d}, {RESP_SLVERR, 32'h0})
    dft_host_inst.wr(12'hFFC, 32'h1, r);
    `CHK(r, RESP_SLVERR)
    $display("Test registers done");
    // Loop settings go in before targets and enable, since targets steer a live loop.
    wr(IDX_LOW_LOC, 32'h30);
    wr(IDX_LOW_R2, 32'h30);
    wr(IDX_START_R1 + 10'h2, 32'h7F);
    wr(IDX_TARGET_R1, 32'h40);
    wr(IDX_CTRL, 32'h3);
    t1 <= 8'h50;
    tl <= 8'h20;
    t2 <= 8'h20;
    ticks(7);
    rd(IDX_START_R1, {24'h0, RST_START});
    ticks(9);
    dft_host_inst.rd({IDX_START_R1, 2'b00}, d, r);
    `CHK(d < 32'h5A, 1'b1)
    `CHK(r, RESP_OKAY)
    rd(IDX_START_R1 + 10'h1, 32'h5B);
    rd(IDX_START_R1 + 10'h2, 32'h7F);
    $display("Test loop done");
    rd(IDX_STATUS, 32'h6);
    `CHK(alb, 1'b0)
    wr(IDX_STATUS, 32'h1FF);
    t1 <= 8'h80;
    tl <= 8'h40;
    t2 <= 8'h40;
    ticks(1);
    rd(IDX_STATUS, 32'h8);
    rd(IDX_TEMP_R1, 32'h80);
    // No ticks follow, so a new cycle code only has to read back.
    wr(IDX_CYCLE, 32'h0000_0149);
    rd(IDX_CYCLE, 32'h0000_0149);
    $display("Test flags done");
    wr(IDX_START_R1, 32'h70);
    repeat (3) @(posedge mclk);
    `CHK({fon, d1, dl, d2}, {3'h1, 8'h10, 16'h0})
    wr(IDX_RANGE, 32'h1);
    repeat (3) @(posedge mclk);
    `CHK(d1, 8'h20)
    t2 <= 8'hA5;
    repeat (4) @(posedge mclk);
    `CHK({fon, d1, dl, d2}, {3'h7, 24'hFFFFFF})
    t2 <= 8'hA1;
    repeat (4) @(posedge mclk);
    `CHK({fon, d1, dl, d2}, {3'h7, 24'hFFFFFF})
    t2 <= 8'h9F;
    repeat (4) @(posedge mclk);
    // Remote 2 still sits above its start temperature of 0x7F once the override ends.
    `CHK({fon, d1, dl, d2}, {3'h5, 8'h20, 8'h00, 8'h20})
    $display("Test fan drive done");
    test_done();
  end
endmodule
`default_nettype wire
